/* common/radio_disable_pkg.sv */
// Constants and carrier types for the radio disable control block.
// Assumes a single 50 MHz reference clock.
`default_nettype none
package radio_disable_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned SHUTDOWN_LIMIT_S = 30;
  localparam int unsigned RESUME_LIMIT_S   = 1;
  // Longest times as exact cycle counts
  localparam longint unsigned SHUTDOWN_CYCLES = longint'(SHUTDOWN_LIMIT_S) * CLK_HZ;
  localparam longint unsigned RESUME_CYCLES   = longint'(RESUME_LIMIT_S) * CLK_HZ;
  localparam int unsigned TIMER_W  = 31;
  localparam int unsigned SYNC_W   = 2;

  // ----------------------------------------
  // Radio selection
  // ----------------------------------------
  localparam int unsigned NUM_RADIOS = 3;
  localparam int unsigned RADIO_PAN  = 0;
  localparam int unsigned RADIO_LAN  = 1;
  localparam int unsigned RADIO_WAN  = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [2:0] IND_RESET_N = 3'h7;

  typedef enum logic [1:0] {
    ST_RUN    = 2'h0,
    ST_DETACH = 2'h1,
    ST_OFF    = 2'h2,
    ST_RESUME = 2'h3
  } ctrl_state_type;

  typedef struct packed {
    logic [NUM_RADIOS-1:0] enable;
    logic [NUM_RADIOS-1:0] indicator_n;
  } radio_out_type;

  typedef struct packed {
    ctrl_state_type        state;
    logic [TIMER_W-1:0]    timer;
    logic                  detach_req;
    logic                  resuming;
    radio_out_type         radio;
  } ctrl_reg_type;

endpackage
`default_nettype wire

/* verilog/disable_sync.sv */
// Two-stage synchroniser for the asynchronous disable level.
// Assumes the pin has a pull-up outside; reset value is released high.
`timescale 1ns/1ns
`default_nettype none
module disable_sync (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // Level
  input  wire logic i_async,
  output logic      o_sync
);
  logic [radio_disable_pkg::SYNC_W-1:0] stages_q;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      stages_q <= 2'h3;
    end else begin
      stages_q <= {stages_q[0], i_async};
    end
  end

  assign o_sync = stages_q[1];
endmodule
`default_nettype wire

/* verilog/radio_disable_control.sv */
// Radio kill-switch control: gates every radio from the shared disable line
// and the host enable setting, and drives the active-low indicators.
// Assumes the host debounces the line and holds it defined while powered.
//
// Operation
// R1: While the disable line is low every radio is turned off.
// R2: The line is accepted asynchronously at any moment.
// R3: The host debounces switch bounce before the line reaches the card.
// R4: On assertion the card asks radio firmware to detach at once.
// R5: Radio operation is stopped no later than 30 seconds after first assertion.
// R6: Once disabling is done the indicator shows the disabled condition.
// R7: After release, resuming starts and is shown within one second; the code ignores a release in ST_DETACH until detach done or timeout.
// R8: RF is allowed only when the line is high and software enables it.
// R9: The line is only sensed, never driven.
// R10: The host keeps the line at a defined level while aux supply is present.
// R11: The indicator outputs are active low.
// R12: An indicator is off whenever its radio cannot transmit, on otherwise.
// R13: The line passes a two-stage synchroniser before use.
// R14: A timer from first assertion forces hard shutdown at the limit.
`timescale 1ns/1ns
`default_nettype none
module radio_disable_control #(
  parameter longint unsigned SHUTDOWN_CYCLES = radio_disable_pkg::SHUTDOWN_CYCLES,
  parameter longint unsigned RESUME_CYCLES   = radio_disable_pkg::RESUME_CYCLES
) (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // Shared disable line, sensed only
  input  wire logic       i_radio_disable_n,
  // Host software enable per radio
  input  wire logic [2:0] i_host_radio_enable_setting,
  // Radio firmware handshake
  input  wire logic       i_detach_done,
  output logic            o_detach_req,
  output logic            o_resuming,
  // Radio RF gates
  output logic [2:0]      o_rf_enable,
  // Indicators, active low
  output logic            o_personal_net_indicator_n,
  output logic            o_local_net_indicator_n,
  output logic            o_wide_net_indicator_n
);
  localparam logic [30:0] SHUT_LAST   = 31'(SHUTDOWN_CYCLES - 1);
  localparam logic [30:0] RESUME_LAST = 31'(RESUME_CYCLES - 1);

  logic                           hw_enable;
  radio_disable_pkg::ctrl_reg_type st_q;
  radio_disable_pkg::ctrl_reg_type st_d;

  // ----------------------------------------
  // Synchroniser
  // ----------------------------------------
  // R13: two-stage input sync
  // R2: asynchronous edges accepted
  disable_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   (i_radio_disable_n),
    .o_sync    (hw_enable)
  );

  function automatic logic [2:0] rf_gate(input logic hw, input logic [2:0] sw);
    rf_gate = hw ? sw : 3'h0;
  endfunction

  // ----------------------------------------
  // Control
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q.state)
      radio_disable_pkg::ST_RUN: begin
        if (!hw_enable) begin
          // R4: request detach early
          st_d.state      = radio_disable_pkg::ST_DETACH;
          st_d.detach_req = 1'b1;
          st_d.timer      = 31'h0;
        end
      end
      radio_disable_pkg::ST_DETACH: begin
        st_d.timer = st_q.timer + 31'h1;
        // R14: timeout forces shutdown
        // R5: stopped within 30 s
        if (i_detach_done || st_q.timer >= SHUT_LAST) begin
          st_d.state      = radio_disable_pkg::ST_OFF;
          st_d.detach_req = 1'b0;
        end
      end
      radio_disable_pkg::ST_OFF: begin
        // R7: start resuming on release
        if (hw_enable) begin
          st_d.state    = radio_disable_pkg::ST_RESUME;
          st_d.resuming = 1'b1;
          st_d.timer    = 31'h0;
        end
      end
      radio_disable_pkg::ST_RESUME: begin
        st_d.timer = st_q.timer + 31'h1;
        if (!hw_enable) begin
          st_d.state      = radio_disable_pkg::ST_DETACH;
          st_d.resuming   = 1'b0;
          st_d.detach_req = 1'b1;
          st_d.timer      = 31'h0;
        end else if (st_q.timer >= RESUME_LAST) begin
          st_d.state    = radio_disable_pkg::ST_RUN;
          st_d.resuming = 1'b0;
        end
      end
      default: begin
        st_d.state = radio_disable_pkg::ST_OFF;
      end
    endcase
    // R8: hardware and software both enable
    // R1: line low stops every radio
    if (st_d.state == radio_disable_pkg::ST_RUN || st_d.state == radio_disable_pkg::ST_RESUME) begin
      st_d.radio.enable = rf_gate(hw_enable, i_host_radio_enable_setting);
    end else begin
      st_d.radio.enable = 3'h0;
    end
    // R6: indicator shows disabled
    // R12: lit only when able to transmit
    st_d.radio.indicator_n = ~st_d.radio.enable;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q.state             <= radio_disable_pkg::ST_RUN;
      st_q.timer             <= 31'h0;
      st_q.detach_req        <= 1'b0;
      st_q.resuming          <= 1'b0;
      st_q.radio.enable      <= 3'h0;
      st_q.radio.indicator_n <= radio_disable_pkg::IND_RESET_N;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // R9: line is input only
  assign o_detach_req = st_q.detach_req;
  assign o_resuming   = st_q.resuming;
  assign o_rf_enable  = st_q.radio.enable;
  // R11: active-low indicators
  assign o_personal_net_indicator_n = st_q.radio.indicator_n[radio_disable_pkg::RADIO_PAN];
  assign o_local_net_indicator_n    = st_q.radio.indicator_n[radio_disable_pkg::RADIO_LAN];
  assign o_wide_net_indicator_n     = st_q.radio.indicator_n[radio_disable_pkg::RADIO_WAN];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_line_low;
    !hw_enable;
  endsequence

  a_low_kills_rf: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R1
    s_line_low |=> (o_rf_enable == 3'h0)) else $error("RF on while line low");

  a_rf_needs_both: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R8
    ((o_rf_enable & ~$past(i_host_radio_enable_setting)) == 3'h0))
    else $error("RF on without software enable");

  a_detach_on_low: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R4
    (st_q.state == radio_disable_pkg::ST_RUN && !hw_enable) |=> o_detach_req)
    else $error("Detach not requested");

  a_shutdown_bound: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R5
    (st_q.state == radio_disable_pkg::ST_DETACH) |-> (st_q.timer <= SHUT_LAST))
    else $error("Shutdown exceeded limit");

  a_timeout_forces: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R14
    (st_q.state == radio_disable_pkg::ST_DETACH && st_q.timer == SHUT_LAST)
    |=> (st_q.state != radio_disable_pkg::ST_DETACH)) else $error("Timeout ignored");

  a_off_shows_dark: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R6
    (st_q.state == radio_disable_pkg::ST_OFF) |-> (st_q.radio.indicator_n == 3'h7))
    else $error("Indicator lit while disabled");

  a_indicator_match: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R12
    (st_q.radio.indicator_n == ~o_rf_enable)) else $error("Indicator mismatch");

  a_resume_shown: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R7
    (st_q.state == radio_disable_pkg::ST_OFF && hw_enable) |=> o_resuming)
    else $error("Resume not shown");

  a_sync_delay: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R13
    $fell(hw_enable) |-> ##1 (o_rf_enable == 3'h0)) else $error("Sync path broken");
endmodule
`default_nettype wire

/* dv/host_switch_model.sv */
// Host side model: user switch and host software enable setting.
// Assumes requests from the bench arrive just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module host_switch_model (
  // Clock
  input  wire logic       i_ref_clk,
  // Bench requests
  input  wire logic       i_switch_off,
  input  wire logic [2:0] i_sw_enable,
  // Lines to the card
  output logic            o_radio_disable_n,
  output logic [2:0]      o_host_radio_enable_setting
);
  logic       line_q    = 1'b1;
  logic [2:0] setting_q = 3'h7;
  always @(posedge i_ref_clk) begin
    line_q <= #1 ~i_switch_off;
    setting_q <= #1 i_sw_enable;
  end
  assign o_radio_disable_n           = line_q;
  assign o_host_radio_enable_setting = setting_q;
endmodule
`default_nettype wire

/* dv/tb.sv */
// Testbench for the radio disable control block.
// Assumes short shutdown and resume counts set below.
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam longint unsigned SHUT_N = 40;
  localparam longint unsigned RES_N  = 10;
  logic       i_ref_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic       sw_off = 1'b0;
  logic [2:0] sw_en = 3'h7;
  logic       done = 1'b0;
  logic       line_n;
  logic [2:0] set_en;
  logic       det;
  logic       res;
  logic [2:0] rf;
  wire logic [2:0] ind_n;
  int         bad_count = 0;
  int         total_checks = 0;
  int         n;
  always #10 i_ref_clk = ~i_ref_clk;
  host_switch_model host_u (.i_ref_clk(i_ref_clk), .i_switch_off(sw_off), .i_sw_enable(sw_en),
    .o_radio_disable_n(line_n), .o_host_radio_enable_setting(set_en));
  radio_disable_control #(.SHUTDOWN_CYCLES(SHUT_N), .RESUME_CYCLES(RES_N)) dut_u (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_radio_disable_n(line_n),
    .i_host_radio_enable_setting(set_en), .i_detach_done(done), .o_detach_req(det),
    .o_resuming(res), .o_rf_enable(rf), .o_personal_net_indicator_n(ind_n[0]),
    .o_local_net_indicator_n(ind_n[1]), .o_wide_net_indicator_n(ind_n[2]));
  task automatic close_out();
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask
  // Bounded wait: detach (0), resuming (1), all radios off (2)
  task automatic wait_on(input int sel, input logic val, input int lim);
    logic cur;
    n = 0;
    do begin
      step(1);
      n++;
      cur = (sel == 0) ? det : (sel == 1) ? res : (rf === 3'h0);
      if (n > lim) begin
        bad_count++;
        close_out();
      end
    end while (cur !== val);
  endtask
  task automatic t_settings();
    for (int v = 0; v < 8; v++) begin
      sw_en = v[2:0];
      step(3);
      chk({5'h0, rf}, {5'h0, v[2:0]});
      chk({5'h0, ind_n}, {5'h0, ~v[2:0]});
    end
  endtask
  task automatic t_disable();
    sw_en = 3'h7;
    sw_off = 1'b1;
    wait_on(2, 1'b1, 4);
    chk(8'(n), 8'h04);
    chk({7'h0, det}, 8'h01);
    chk({5'h0, ind_n}, 8'h07);
    step(5);
    chk({5'h0, rf}, 8'h00);
    done = 1'b1;
    wait_on(0, 1'b0, 3);
    done = 1'b0;
    step(4);
    chk({5'h0, rf | ~ind_n}, 8'h00);
  endtask
  task automatic t_release();
    sw_en = 3'h5;
    sw_off = 1'b0;
    wait_on(1, 1'b1, 4);
    chk({5'h0, rf}, 8'h05);
    chk({5'h0, ind_n}, 8'h02);
    step(2);
    sw_off = 1'b1;
    wait_on(2, 1'b1, 4);
    chk({6'h0, det, res}, 8'h02);
    done = 1'b1;
    wait_on(0, 1'b0, 3);
    done = 1'b0;
    sw_off = 1'b0;
    wait_on(1, 1'b1, 4);
    wait_on(1, 1'b0, RES_N + 4);
    chk(8'(n), 8'(RES_N));
    chk({5'h0, rf}, 8'h05);
  endtask
  task automatic t_timeout();
    sw_off = 1'b1;
    wait_on(0, 1'b1, 4);
    wait_on(0, 1'b0, SHUT_N + 4);
    chk(8'(n), 8'(SHUT_N));
    chk({5'h0, rf}, 8'h00);
    chk({5'h0, ind_n}, 8'h07);
    sw_off = 1'b0;
    wait_on(1, 1'b1, 4);
  endtask
  // Mid-run reset, line released, setting 5
  task automatic t_reset();
    i_rst = 1'b1;
    step(2);
    chk({5'h0, rf}, 8'h00);
    chk({5'h0, ind_n}, 8'h07);
    chk({6'h0, det, res}, 8'h00);
    i_rst = 1'b0;
    step(1);
    chk({5'h0, rf}, 8'h05);
    chk({5'h0, ind_n}, 8'h02);
  endtask
  initial begin
    repeat (6) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    step(3);
    t_settings();
    t_disable();
    t_release();
    t_timeout();
    step(RES_N + 4);
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire
